// >>> src/remap_regs_pkg.sv
package remap_regs_pkg;
	// configuration byte offsets, low byte of each 16-bit register
	localparam logic [7:0] OFS_WINDOW_BOTTOM = 8'hc6;
	localparam logic [7:0] OFS_WINDOW_TOP = 8'hc8;
	localparam logic [7:0] OFS_SCRATCH = 8'hde;
	localparam logic [7:0] OFS_FUNC_HIDE = 8'he0;
	// reset values
	localparam logic [15:0] RST_WINDOW_BOTTOM = 16'h03ff;
	localparam logic [15:0] RST_WINDOW_TOP = 16'h0000;
	localparam logic [15:0] RST_SCRATCH = 16'h0000;
	localparam logic [15:0] RST_FUNC_HIDE = 16'h1d1d;
	// field layout
	localparam int BOUND_W = 10;
	localparam int ADDR_W = 36;
	localparam int BOUND_LSB = 26;
	// writable bits of the hide register: 0, 2, 3, 4
	localparam logic [15:0] HIDE_WMASK = 16'h001d;
	localparam logic [15:0] BOUND_WMASK = 16'h03ff;
	localparam int HIDE_DEV0 = 0;
	localparam int HIDE_DEV2 = 2;
	localparam int HIDE_DEV3 = 3;
	localparam int HIDE_DEV4 = 4;
endpackage : remap_regs_pkg

// >>> src/remap_window_regs.sv
// What this block does
// RULE_01 - upper remap bound: 10-bit RW field bits 9:0 for address 35:26, resets zero
// RULE_02 - upper bound compare treats address 25:0 as ones, top address included
// RULE_03 - window disabled whenever upper bound is below lower bound
// RULE_04 - lower bound gives address 35:26, low bits zero, 64-MB aligned, included
// RULE_05 - access inside window when enabled and bits 35:26 lie within both bounds
// RULE_06 - 16-bit scratch register, resets zero, read/write, no effect on behaviour
// RULE_07 - hide bits 0,2,3,4 map devices 0,2,3,4; zero visible, one hidden
// RULE_08 - hide register resets to 1d1d, all functions hidden, bits 1 and 15:5 reserved
// RULE_09 - hidden function 1 makes device enumerate as single-function
// RULE_10 - software must not write undefined offsets nor expect zero from them
`timescale 1ns/1ns
`default_nettype none
module remap_window_regs
	import remap_regs_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [7:0] CFG_ADDR,
	input wire logic CFG_WR,
	input wire logic [1:0] CFG_BE,
	input wire logic [15:0] CFG_WDATA,
	output logic [15:0] CFG_RDATA,
	input wire logic [ADDR_W-1:0] ACC_ADDR,
	output logic ACC_IN_WINDOW,
	output logic WINDOW_EN,
	output logic [3:0] FUNC1_VISIBLE,
	output logic [3:0] MULTI_FUNC
);
	logic [15:0] bottom_r, top_r, scratch_r, hide_r;
	logic [15:0] wmask;

	// byte lanes become a bit mask for writes
	assign wmask = {{8{CFG_BE[1]}}, {8{CFG_BE[0]}}};

	wire sel_bottom = (CFG_ADDR == OFS_WINDOW_BOTTOM);
	wire sel_top = (CFG_ADDR == OFS_WINDOW_TOP);
	wire sel_scratch = (CFG_ADDR == OFS_SCRATCH);
	wire sel_hide = (CFG_ADDR == OFS_FUNC_HIDE);

	// reserved bits never take a write, so they keep their reset values
	wire [15:0] bottom_nxt = (bottom_r & ~(wmask & BOUND_WMASK)) | (CFG_WDATA & wmask & BOUND_WMASK);
	wire [15:0] top_nxt = (top_r & ~(wmask & BOUND_WMASK)) | (CFG_WDATA & wmask & BOUND_WMASK); // see RULE_01
	wire [15:0] scratch_nxt = (scratch_r & ~wmask) | (CFG_WDATA & wmask); // see RULE_06
	wire [15:0] hide_nxt = (hide_r & ~(wmask & HIDE_WMASK)) | (CFG_WDATA & wmask & HIDE_WMASK); // see RULE_07

	// write strobes qualified once, so each register process stays short; CE low freezes all
	wire wr_go = CE && CFG_WR;
	wire wr_bottom = wr_go && sel_bottom;
	wire wr_top = wr_go && sel_top;
	wire wr_scratch = wr_go && sel_scratch;
	wire wr_hide = wr_go && sel_hide;

	// lower bound lives here as well, since the compare needs both ends
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			bottom_r <= RST_WINDOW_BOTTOM; // see RULE_04
		end else if (wr_bottom) begin
			bottom_r <= bottom_nxt;
		end
	end

	// upper bound resets to zero, below the bottom, so the window starts off
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			top_r <= RST_WINDOW_TOP; // see RULE_01
		end else if (wr_top) begin
			top_r <= top_nxt; // see RULE_01
		end
	end

	// scratch storage feeds only the read mux, nothing else in the block
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			scratch_r <= RST_SCRATCH; // see RULE_06
		end else if (wr_scratch) begin
			scratch_r <= scratch_nxt; // see RULE_06
		end
	end

	// hide flags start set: every function 1 stays hidden until software opens it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			hide_r <= RST_FUNC_HIDE; // see RULE_08
		end else if (wr_hide) begin
			hide_r <= hide_nxt; // see RULE_07
		end
	end

	// read mux; unmapped offsets read zero, software must not rely on it
	assign CFG_RDATA = sel_bottom ? bottom_r :
		sel_top ? top_r :
		sel_scratch ? scratch_r :
		sel_hide ? hide_r : 16'h0000; // see RULE_10

	// window decode, comparing only bits 35:26: low bits of bottom are zero, of top all ones
	wire [BOUND_W-1:0] lo_bound = bottom_r[BOUND_W-1:0]; // see RULE_04
	wire [BOUND_W-1:0] hi_bound = top_r[BOUND_W-1:0]; // see RULE_02
	wire [BOUND_W-1:0] acc_hi = ACC_ADDR[ADDR_W-1:BOUND_LSB];
	assign WINDOW_EN = !(hi_bound < lo_bound); // see RULE_03
	assign ACC_IN_WINDOW = WINDOW_EN && (acc_hi >= lo_bound) && (acc_hi <= hi_bound); // see RULE_05

	// hide flag position of each device, in port order dev0, dev2, dev3, dev4
	localparam int HIDE_POS [4] = '{HIDE_DEV0, HIDE_DEV2, HIDE_DEV3, HIDE_DEV4};
	wire [3:0] vis_w;

	// one slice per device; hiding function 1 also drops the multi-function mark,
	// so enumeration finds function 0 alone and the device looks single-function
	for (genvar dev = 0; dev < 4; dev++) begin : g_dev
		assign vis_w[dev] = !hide_r[HIDE_POS[dev]]; // see RULE_07

		a_dev_hidden: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_09
			hide_r[HIDE_POS[dev]] |-> (!FUNC1_VISIBLE[dev] && !MULTI_FUNC[dev]))
			else $error("hidden function 1 still shown");
		a_dev_shown: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_07
			!hide_r[HIDE_POS[dev]] |-> (FUNC1_VISIBLE[dev] && MULTI_FUNC[dev]))
			else $error("visible function 1 not shown");
	end

	// header multi-function indication follows visibility
	assign FUNC1_VISIBLE = vis_w; // see RULE_07
	assign MULTI_FUNC = vis_w; // see RULE_09

	// window decode checks, on the raw register fields rather than the decode wires
	a_window_off: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_03
		(top_r[BOUND_W-1:0] < bottom_r[BOUND_W-1:0]) |-> !ACC_IN_WINDOW)
		else $error("window active with top below bottom");

	a_win_enable: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_03
		WINDOW_EN == (top_r[BOUND_W-1:0] >= bottom_r[BOUND_W-1:0]))
		else $error("window enable does not follow bounds");

	a_top_incl: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_02
		(WINDOW_EN && ACC_ADDR[ADDR_W-1:BOUND_LSB] == top_r[BOUND_W-1:0]) |-> ACC_IN_WINDOW)
		else $error("top boundary not included");

	a_bottom_incl: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_04
		(WINDOW_EN && ACC_ADDR[ADDR_W-1:BOUND_LSB] == bottom_r[BOUND_W-1:0]) |-> ACC_IN_WINDOW)
		else $error("bottom boundary not included");

	a_below_out: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_05
		(ACC_ADDR[ADDR_W-1:BOUND_LSB] < bottom_r[BOUND_W-1:0]) |-> !ACC_IN_WINDOW)
		else $error("address below window hit");

	a_above_out: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_05
		(ACC_ADDR[ADDR_W-1:BOUND_LSB] > top_r[BOUND_W-1:0]) |-> !ACC_IN_WINDOW)
		else $error("address above window hit");

	a_inside_hit: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_05
		(ACC_ADDR[ADDR_W-1:BOUND_LSB] >= bottom_r[BOUND_W-1:0] &&
		ACC_ADDR[ADDR_W-1:BOUND_LSB] <= top_r[BOUND_W-1:0]) |-> ACC_IN_WINDOW)
		else $error("address inside window missed");

	// bound registers: full writes land, reserved bits stay zero, no write means no change
	a_top_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_01
		(CE && CFG_WR && sel_top && CFG_BE == 2'b11) |=> top_r == ($past(CFG_WDATA) & BOUND_WMASK))
		else $error("top bound write lost");

	a_bottom_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_04
		(wr_bottom && CFG_BE == 2'b11) |=> bottom_r == ($past(CFG_WDATA) & BOUND_WMASK))
		else $error("bottom bound write lost");

	a_top_resv: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_01
		(top_r & ~BOUND_WMASK) == 16'h0000)
		else $error("top reserved bits set");

	a_bottom_resv: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_04
		(bottom_r & ~BOUND_WMASK) == 16'h0000)
		else $error("bottom reserved bits set");

	a_top_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_01
		!wr_top |=> $stable(top_r))
		else $error("top bound changed without write");

	a_bottom_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_04
		!wr_bottom |=> $stable(bottom_r))
		else $error("bottom bound changed without write");

	// scratch storage
	a_scratch_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_06
		(wr_scratch && CFG_BE == 2'b11) |=> scratch_r == $past(CFG_WDATA))
		else $error("scratch write lost");

	a_scratch_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_06
		!(CE && CFG_WR && sel_scratch) |=> $stable(scratch_r))
		else $error("scratch changed without write");

	a_scratch_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_06
		sel_scratch |-> CFG_RDATA == scratch_r)
		else $error("scratch read wrong");

	// hide register
	a_hide_resv: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_08
		(hide_r & ~HIDE_WMASK) == (RST_FUNC_HIDE & ~HIDE_WMASK))
		else $error("hide reserved bits changed");

	a_hide_vis: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_07
		(CE && CFG_WR && sel_hide && CFG_BE[0]) |=> FUNC1_VISIBLE[0] == !$past(CFG_WDATA[0]))
		else $error("device 0 visibility wrong");

	a_hide_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_07
		(wr_hide && CFG_BE[0]) |=> (hide_r & HIDE_WMASK) == ($past(CFG_WDATA) & HIDE_WMASK))
		else $error("hide flags write lost");

	a_hide_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_08
		!wr_hide |=> $stable(hide_r))
		else $error("hide flags changed without write");

	a_single_func: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_09
		hide_r[HIDE_DEV2] |-> !MULTI_FUNC[1])
		else $error("hidden device shows multi-function");

	// read mux
	a_top_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_01
		sel_top |-> CFG_RDATA == top_r)
		else $error("top bound read wrong");

	a_hide_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_08
		sel_hide |-> CFG_RDATA == hide_r)
		else $error("hide flags read wrong");

	a_unmapped_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // see RULE_10
		!(sel_bottom || sel_top || sel_scratch || sel_hide) |-> CFG_RDATA == 16'h0000)
		else $error("unmapped offset reads nonzero");
endmodule : remap_window_regs
`default_nettype wire

// >>> tb/remap_window_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module remap_window_regs_bench;
	import remap_regs_pkg::*;
	logic clk_sys = 0, rst_n = 0, ce = 1, cfg_wr = 0, in_win, win_en;
	logic [1:0] cfg_be = 2'h3;
	logic [7:0] cfg_addr = 8'h00;
	logic [15:0] cfg_wdata = 16'h0000, rdata;
	logic [35:0] acc_addr = 36'h0;
	logic [3:0] vis, multi;
	int error_cnt = 0, checked = 0;
	remap_window_regs u_remap_window_regs(.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .CFG_ADDR(cfg_addr),
		.CFG_WR(cfg_wr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata), .CFG_RDATA(rdata), .ACC_ADDR(acc_addr),
		.ACC_IN_WINDOW(in_win), .WINDOW_EN(win_en), .FUNC1_VISIBLE(vis), .MULTI_FUNC(multi));
	// 250 MHz system clock
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// one strobe per write, inputs moved 1 ns after the edge
	task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge clk_sys);
		#1 {cfg_addr, cfg_be, cfg_wdata, cfg_wr} = {a, be, d, 1'b1};
		@(posedge clk_sys);
		#1 cfg_wr = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		#1 cfg_addr = a;
		#1 chk(rdata, e);
	endtask : rd
	// classify an address: upper ten bits plus low part
	task automatic win(input logic [9:0] h, input logic [25:0] l, input logic e);
		@(posedge clk_sys);
		#1 acc_addr = {h, l};
		#1 chk({15'h0, in_win}, {15'h0, e});
	endtask : win
	task automatic t_reset;
		rd(OFS_WINDOW_BOTTOM, 16'h03ff);
		rd(OFS_WINDOW_TOP, 16'h0000);
		rd(OFS_SCRATCH, 16'h0000);
		rd(OFS_FUNC_HIDE, 16'h1d1d);
		chk({12'h0, vis}, 16'h0000);
		chk({15'h0, win_en}, 16'h0000);
		$display("reset values done");
	endtask : t_reset
	task automatic t_window;
		wr(OFS_WINDOW_TOP, 2'h3, 16'hffff);
		rd(OFS_WINDOW_TOP, 16'h03ff);
		win(10'h3ff, 26'h3ffffff, 1'b1);
		wr(OFS_WINDOW_BOTTOM, 2'h3, 16'hfc05);
		rd(OFS_WINDOW_BOTTOM, 16'h0005);
		wr(OFS_WINDOW_TOP, 2'h3, 16'h0007);
		win(10'h005, 26'h0, 1'b1);
		win(10'h004, 26'h3ffffff, 1'b0);
		win(10'h007, 26'h3ffffff, 1'b1);
		win(10'h008, 26'h0, 1'b0);
		wr(OFS_WINDOW_TOP, 2'h3, 16'h0004);
		chk({15'h0, win_en}, 16'h0000);
		win(10'h005, 26'h0, 1'b0);
		$display("window bounds done");
	endtask : t_window
	task automatic t_hide;
		wr(OFS_FUNC_HIDE, 2'h3, 16'hffe2);
		rd(OFS_FUNC_HIDE, 16'h1d00);
		chk({8'h0, vis, multi}, 16'h00ff);
		wr(OFS_FUNC_HIDE, 2'h1, 16'h0004);
		chk({8'h0, vis, multi}, 16'h00dd);
		$display("function hide done");
	endtask : t_hide
	// byte enables, clock enable and an unmapped read
	task automatic t_scratch;
		wr(OFS_SCRATCH, 2'h1, 16'ha5c3);
		wr(OFS_SCRATCH, 2'h2, 16'h5a00);
		rd(OFS_SCRATCH, 16'h5ac3);
		@(posedge clk_sys);
		#1 ce = 0;
		wr(OFS_SCRATCH, 2'h3, 16'h1111);
		ce = 1;
		rd(OFS_SCRATCH, 16'h5ac3);
		rd(8'hd0, 16'h0000);
		$display("scratch done");
	endtask : t_scratch
	// reset in mid-run must put scratch, upper bound and hide flags back
	task automatic t_midreset;
		wr(OFS_SCRATCH, 2'h3, 16'h1234);
		wr(OFS_FUNC_HIDE, 2'h3, 16'h0000);
		wr(OFS_WINDOW_TOP, 2'h3, 16'h03ff);
		chk({8'h0, vis, multi}, 16'h00ff);
		@(posedge clk_sys);
		#1 rst_n = 0;
		@(posedge clk_sys);
		#1 rst_n = 1;
		rd(OFS_SCRATCH, 16'h0000);
		rd(OFS_WINDOW_TOP, 16'h0000);
		rd(OFS_FUNC_HIDE, 16'h1d1d);
		chk({8'h0, vis, multi}, 16'h0000);
		$display("mid-run reset done");
	endtask : t_midreset
	task automatic close_out;
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// the whole run needs well under a microsecond
	initial begin
		#5000 error_cnt++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		#1 rst_n = 1;
		t_reset();
		t_window();
		t_hide();
		t_scratch();
		t_midreset();
		close_out();
	end
endmodule : remap_window_regs_bench
`default_nettype wire
